// [bdt_consts.svh]
// register map, field positions, reset values and counts of the divider timer
`ifndef BDT_CONSTS_SVH
`define BDT_CONSTS_SVH
// register byte addresses
`define BDT_ADDR_CTRL 12'h004
`define BDT_ADDR_DIV 12'h008
`define BDT_ADDR_STAT 12'h00C
// control field positions
`define BDT_C_SEL_LO 0
`define BDT_C_SEL_HI 1
`define BDT_C_POL 2
`define BDT_C_MODE 3
`define BDT_C_MASTER_RESET_IN 4
`define BDT_C_BYP 5
// reset values: recycle mode, internal oscillator
`define BDT_CTRL_RST 6'h08
`define BDT_DIV_RST 16'h0003
// counter stage taps and steps
`define BDT_TAP_13 12
`define BDT_TAP_10 9
`define BDT_TAP_16 15
`define BDT_STEP_ONE 16'h0001
`define BDT_STEP_STAGE9 16'h0100
// ratio select codes {high, low}
`define BDT_SEL_8192 2'h0
`define BDT_SEL_1024 2'h1
`define BDT_SEL_256 2'h2
`define BDT_SEL_65536 2'h3
// startup sequencer: strap needs two flops before it is caught
`define BDT_ST_CATCH 3'h2
`define BDT_ST_POR_ON 3'h3
`define BDT_ST_END 3'h7
`endif

// [bdt_pkg.sv]
// types of the binary divider timer
package bdt_pkg;
    // state of the oscillator tick generator
    typedef struct packed {
        logic ext_s1;
        logic ext_s2;
        logic ext_d;
        logic [15:0] div_cnt;
        logic tick;
    } bdt_tick_st_t;
    // state of the timer core and its bus slave
    typedef struct packed {
        logic [5:0] ctrl;
        logic [15:0] div;
        logic [15:0] count;
        logic latch;
        logic mode_d;
        logic [1:0] strap_s;
        logic auto_off;
        logic [2:0] st_cnt;
        logic out;
        logic pready;
        logic pslverr;
        logic [31:0] prdata;
    } bdt_st_t;
endpackage

// [bdt_tick_gen.sv]
// oscillator model: internal divider or synchronised external clock, one-cycle ticks except with divider 0, which ticks every cycle
`include "bdt_consts.svh"
module bdt_tick_gen (
    // clock and reset
    input wire logic i_core_clk,
    input wire logic i_nrst,
    // control
    input wire logic i_run,
    input wire logic i_bypass,
    input wire logic [15:0] i_div,
    // external clock pin
    input wire logic i_ext_clk,
    // count enable
    output logic o_tick
);
    bdt_pkg::bdt_tick_st_t st;
    bdt_pkg::bdt_tick_st_t next_st;

    // next state of the oscillator
    always_comb begin
        next_st = st;
        next_st.ext_s1 = i_ext_clk;
        next_st.ext_s2 = st.ext_s1;
        next_st.ext_d = st.ext_s2;
        next_st.tick = 1'b0;
        // R8 stopped in reset
        if (!i_run) begin
            next_st.div_cnt = '0;
        // R14 external clock counts its rising edges
        end else if (i_bypass) begin
            next_st.div_cnt = '0;
            next_st.tick = st.ext_s2 & ~st.ext_d;
        end else if (st.div_cnt >= i_div) begin
            next_st.div_cnt = '0;
            next_st.tick = 1'b1;
        end else begin
            next_st.div_cnt = st.div_cnt + `BDT_STEP_ONE;
        end
    end

    // state register
    always_ff @(posedge i_core_clk) begin
        if (!i_nrst) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    // gate so no tick escapes the cycle a reset begins
    assign o_tick = st.tick & i_run;
endmodule

// [bdt_timer.sv]
// binary divider timer: 16-stage counter, output logic, power-up reset and apb slave
//
// Notes on behaviour
// R1: sixteen-stage binary counter clocked by the oscillator provides the output taps.
// R2: counter advances by one per oscillator rising edge, never on falling edges.
// R3: high select 0: low 0 routes stage 13, low 1 routes stage 10.
// R4: high select 1 uses stage 16; low 0 clocks stage 9 directly, divide 256.
// R5: master reset 1 resets the counter; 0 lets the timer run.
// R6: auto reset input 0 initialises at power-up; 1 disables that reset.
// R7: either reset clears every stage synchronously whatever the count.
// R8: oscillator stops while either reset is active.
// R9: in reset the output equals the polarity select level.
// R10: mode 1 passes the selected stage continuously, a repeating divider.
// R11: mode 0: latch clears at reset, sets after half count, then holds.
// R12: master reset pulse or mode change restarts the single-cycle timing.
// R13: master reset works whether auto reset is enabled or not.
// R14: oscillator may be bypassed by an external clock on its input.
// R15: power-up reset is a pulse after startup when auto reset is enabled.
//
// Added by the designer: the register offsets and register access over APB.
`include "bdt_consts.svh"
module bdt_timer (
    // clock and reset
    input wire logic i_core_clk,
    input wire logic i_nrst,
    // apb slave
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic i_pwrite,
    input wire logic [11:0] i_paddr,
    input wire logic [31:0] i_pwdata,
    output logic o_pready,
    output logic [31:0] o_prdata,
    output logic o_pslverr,
    // pins
    input wire logic i_auto_reset_off,
    input wire logic i_osc_ext_clk,
    output logic o_timer_out
);
    bdt_pkg::bdt_st_t st;
    bdt_pkg::bdt_st_t next_st;
    logic tick;
    logic in_por;
    logic mode_chg;
    logic any_rst;
    logic acc;
    logic wr_en;
    logic addr_ok;
    logic [31:0] rd_data;
    logic [1:0] sel;

    // selected stage of a count for a ratio select
    // R1 sixteen-stage taps
    function automatic logic f_tap(input logic [15:0] cnt, input logic [1:0] s);
        logic t;
        t = cnt[`BDT_TAP_16];
        unique case (s)
            // R3 stage 13 and stage 10
            `BDT_SEL_8192: t = cnt[`BDT_TAP_13];
            `BDT_SEL_1024: t = cnt[`BDT_TAP_10];
            // R4 stage 16 for both low select levels
            default: t = cnt[`BDT_TAP_16];
        endcase
        return t;
    endfunction

    // reset sources, decoded from registered state
    assign sel = {st.ctrl[`BDT_C_SEL_HI], st.ctrl[`BDT_C_SEL_LO]};
    // R15 power-up pulse only when auto reset enabled
    // pulse waits until the strap is caught, so it never starts before the strap value is known
    assign in_por = ~st.auto_off & (st.st_cnt >= `BDT_ST_POR_ON) & (st.st_cnt < `BDT_ST_END);
    // R12 a mode change restarts the one-shot
    assign mode_chg = st.ctrl[`BDT_C_MODE] != st.mode_d;
    // R5 master reset bit holds the counter
    // R13 master reset independent of auto reset
    assign any_rst = st.ctrl[`BDT_C_MASTER_RESET_IN] | in_por | mode_chg;

    // bus decode
    assign acc = i_psel & i_penable;
    assign wr_en = acc & st.pready & i_pwrite;
    assign addr_ok = (i_paddr == `BDT_ADDR_CTRL) | (i_paddr == `BDT_ADDR_DIV) | (i_paddr == `BDT_ADDR_STAT);

    // read mux, unused bits read as zero
    always_comb begin
        rd_data = 32'h0000_0000;
        if (i_paddr == `BDT_ADDR_CTRL) begin
            rd_data = {26'h000_0000, st.ctrl};
        end else if (i_paddr == `BDT_ADDR_DIV) begin
            rd_data = {16'h0000, st.div};
        end else if (i_paddr == `BDT_ADDR_STAT) begin
            rd_data = {12'h000, st.auto_off, any_rst, st.latch, st.out, st.count};
        end
    end

    // oscillator and clock bypass
    bdt_tick_gen u_tick (
        .i_core_clk(i_core_clk),
        .i_nrst(i_nrst),
        // R8 oscillator held while in reset
        .i_run(~any_rst),
        .i_bypass(st.ctrl[`BDT_C_BYP]),
        .i_div(st.div),
        .i_ext_clk(i_osc_ext_clk),
        .o_tick(tick)
    );

    // next state of bus, startup and counter
    always_comb begin
        next_st = st;
        // pready one cycle into the access phase, dropped after the handshake
        next_st.pready = acc & ~st.pready;
        if (acc & ~st.pready) begin
            next_st.prdata = i_pwrite ? 32'h0000_0000 : rd_data;
            next_st.pslverr = ~addr_ok;
        end
        // writes land at the edge where pready is sampled high
        if (wr_en & (i_paddr == `BDT_ADDR_CTRL)) begin
            next_st.ctrl = i_pwdata[5:0];
        end
        if (wr_en & (i_paddr == `BDT_ADDR_DIV)) begin
            next_st.div = i_pwdata[15:0];
        end
        // strap pin through two flops before use
        next_st.strap_s = {st.strap_s[0], i_auto_reset_off};
        // startup count saturates so the power-up pulse never repeats
        if (st.st_cnt != `BDT_ST_END) begin
            next_st.st_cnt = st.st_cnt + 3'h1;
        end
        // R6 strap caught once after release
        if (st.st_cnt == `BDT_ST_CATCH) begin
            next_st.auto_off = st.strap_s[1];
        end
        // delayed mode: a mode change costs one reset cycle
        next_st.mode_d = st.ctrl[`BDT_C_MODE];
        // R7 synchronous clear of all stages
        if (any_rst) begin
            next_st.count = 16'h0000;
            // R11 latch clears at reset
            next_st.latch = 1'b0;
        end else if (tick) begin
            // R4 divide 256 feeds stage 9 straight from the oscillator
            if (sel == `BDT_SEL_256) begin
                next_st.count = st.count + `BDT_STEP_STAGE9;
            // R2 one step per oscillator edge
            end else begin
                next_st.count = st.count + `BDT_STEP_ONE;
            end
        end
        // R11 set after half the selected count, then held
        if (!any_rst && f_tap(next_st.count, {next_st.ctrl[`BDT_C_SEL_HI], next_st.ctrl[`BDT_C_SEL_LO]})) begin
            next_st.latch = 1'b1;
        end
        // R10 recycle passes the stage
        if (next_st.ctrl[`BDT_C_MODE]) begin
            next_st.out = f_tap(next_st.count, {next_st.ctrl[`BDT_C_SEL_HI], next_st.ctrl[`BDT_C_SEL_LO]});
        end else begin
            next_st.out = next_st.latch;
        end
        // R9 polarity sets the reset level
        next_st.out = next_st.out ^ next_st.ctrl[`BDT_C_POL];
    end

    // state register; strap is caught later, never under reset
    always_ff @(posedge i_core_clk) begin
        if (!i_nrst) begin
            st <= '0;
            st.ctrl <= `BDT_CTRL_RST;
            st.div <= `BDT_DIV_RST;
            st.mode_d <= 1'b1;
            st.auto_off <= 1'b1;
        end else begin
            st <= next_st;
        end
    end

    // outputs straight from flops
    assign o_pready = st.pready;
    assign o_prdata = st.prdata;
    assign o_pslverr = st.pslverr;
    assign o_timer_out = st.out;

    // checks
    // one clock domain, so all checks share the core clock and mute in bus reset
    default clocking cb @(posedge i_core_clk);
    endclocking
    default disable iff (!i_nrst);

    property p_count_step;
        tick && !any_rst && sel != `BDT_SEL_256 && !wr_en |=> st.count == $past(st.count) + `BDT_STEP_ONE;
    endproperty
    a_count_step: assert property (p_count_step) else $error("counter did not advance by one"); // R2

    property p_hold_no_tick;
        !tick && !any_rst |=> st.count == $past(st.count);
    endproperty
    a_hold_no_tick: assert property (p_hold_no_tick) else $error("counter moved without a tick"); // R1

    property p_tap_low;
        st.ctrl[`BDT_C_MODE] && !sel[1] |-> o_timer_out == (f_tap(st.count, sel) ^ st.ctrl[`BDT_C_POL]);
    endproperty
    a_tap_low: assert property (p_tap_low) else $error("wrong stage routed for low ratios"); // R3

    property p_stage9;
        tick && !any_rst && sel == `BDT_SEL_256 |=> st.count[7:0] == $past(st.count[7:0])
            && st.count[15:8] == $past(st.count[15:8]) + 8'h01;
    endproperty
    a_stage9: assert property (p_stage9) else $error("stage nine not clocked directly"); // R4

    property p_master;
        st.ctrl[`BDT_C_MASTER_RESET_IN] |=> st.count == 16'h0000 && !st.latch;
    endproperty
    a_master: assert property (p_master) else $error("master reset did not clear"); // R5

    property p_por;
        st.st_cnt == `BDT_ST_POR_ON && !st.auto_off |-> in_por [*4] ##1 !in_por;
    endproperty
    a_por: assert property (p_por) else $error("power-up reset pulse wrong length"); // R15

    property p_osc_stop;
        any_rst |-> !tick;
    endproperty
    a_osc_stop: assert property (p_osc_stop) else $error("oscillator ran during reset"); // R8

    property p_reset_level;
        any_rst && !wr_en |=> o_timer_out == $past(st.ctrl[`BDT_C_POL]);
    endproperty
    a_reset_level: assert property (p_reset_level) else $error("reset output not at polarity"); // R9

    property p_one_shot_hold;
        !st.ctrl[`BDT_C_MODE] && st.latch && !any_rst |=> st.latch;
    endproperty
    a_one_shot_hold: assert property (p_one_shot_hold) else $error("one-shot latch dropped"); // R11

    property p_restart;
        $changed(st.ctrl[`BDT_C_MODE]) |=> st.count == 16'h0000 && !st.latch;
    endproperty
    a_restart: assert property (p_restart) else $error("mode change did not restart"); // R12

    // output routing against the raw stages and the one-shot latch
    property p_recycle_out;
        st.ctrl[`BDT_C_MODE] |-> o_timer_out == (f_tap(st.count, sel) ^ st.ctrl[`BDT_C_POL]);
    endproperty
    a_recycle_out: assert property (p_recycle_out) else $error("recycle output not the selected stage"); // R10

    property p_one_shot_out;
        !st.ctrl[`BDT_C_MODE] |-> o_timer_out == (st.latch ^ st.ctrl[`BDT_C_POL]);
    endproperty
    a_one_shot_out: assert property (p_one_shot_out) else $error("one-shot output not the latch"); // R11

    property p_tap_256;
        st.ctrl[`BDT_C_MODE] && sel == `BDT_SEL_256
            |-> o_timer_out == (st.count[`BDT_TAP_16] ^ st.ctrl[`BDT_C_POL]);
    endproperty
    a_tap_256: assert property (p_tap_256) else $error("divide 256 not on the top stage"); // R4

    property p_tap_65536;
        st.ctrl[`BDT_C_MODE] && sel == `BDT_SEL_65536
            |-> o_timer_out == (st.count[`BDT_TAP_16] ^ st.ctrl[`BDT_C_POL]);
    endproperty
    a_tap_65536: assert property (p_tap_65536) else $error("divide 65536 not on the top stage"); // R4

    // oscillator tick shape
    property p_single_tick;
        !st.ctrl[`BDT_C_BYP] && st.div != 16'h0000 && tick |=> !tick;
    endproperty
    a_single_tick: assert property (p_single_tick) else $error("internal tick longer than one cycle"); // R2

    property p_bypass_edge;
        st.ctrl[`BDT_C_BYP] && $past(st.ctrl[`BDT_C_BYP]) && tick |=> !tick;
    endproperty
    a_bypass_edge: assert property (p_bypass_edge) else $error("external edge counted twice"); // R14

    property p_osc_restart;
        any_rst |=> !tick;
    endproperty
    a_osc_restart: assert property (p_osc_restart) else $error("tick right after a reset cycle"); // R8

    // reset sources
    property p_clear_any;
        any_rst |=> st.count == 16'h0000;
    endproperty
    a_clear_any: assert property (p_clear_any) else $error("reset left a stage set"); // R7

    property p_master_indep;
        st.ctrl[`BDT_C_MASTER_RESET_IN] && st.auto_off |=> st.count == 16'h0000;
    endproperty
    a_master_indep: assert property (p_master_indep) else $error("master reset failed with auto reset off"); // R13

    property p_por_clear;
        in_por |=> st.count == 16'h0000 && !st.latch;
    endproperty
    a_por_clear: assert property (p_por_clear) else $error("power-up reset did not clear"); // R15

    // strap handling
    property p_por_gated;
        st.auto_off |-> !in_por;
    endproperty
    a_por_gated: assert property (p_por_gated) else $error("power-up reset with auto reset off"); // R6

    property p_strap_once;
        st.st_cnt == `BDT_ST_END |=> $stable(st.auto_off);
    endproperty
    a_strap_once: assert property (p_strap_once) else $error("strap value changed after startup"); // R6

    c_recycle_toggle: cover property (st.ctrl[`BDT_C_MODE] && $rose(o_timer_out));
    c_one_shot_set: cover property (!st.ctrl[`BDT_C_MODE] && $rose(st.latch));
    c_bypass_tick: cover property (st.ctrl[`BDT_C_BYP] && tick);
    c_por_pulse: cover property ($rose(in_por));
    c_master_clear: cover property (st.ctrl[`BDT_C_MASTER_RESET_IN] && st.count == 16'h0000);
endmodule

// [bdt_ext_ctrl.sv]
// far-side model: static auto reset strap and bursts on the external clock pin
module bdt_ext_ctrl (
    // clock
    input wire logic i_core_clk,
    // bench control
    input wire logic i_strap,
    input wire logic i_go,
    input wire logic [7:0] i_pulses,
    // pins
    output logic o_auto_reset_off,
    output logic o_ext_clk
);
    timeunit 1ns;
    timeprecision 100ps;
    int ph = 0;
    assign o_auto_reset_off = i_strap;
    // external clock pulses
    // four cycles high, four low; pin stands low outside a burst
    always @(posedge i_core_clk) begin
        if (!i_go) begin
            ph <= 0;
            o_ext_clk <= 1'b0;
        end else if (ph < 8 * int'(i_pulses)) begin
            ph <= ph + 1;
            o_ext_clk <= (ph % 8) < 4;
        end else begin
            o_ext_clk <= 1'b0;
        end
    end
endmodule

// [tb_top.sv]
// self-checking bench of the divider timer: apb driver, note queue and output monitor
`include "bdt_consts.svh"
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin num_errors++; $display("ERROR t=%0t got %h exp %h", $time, a, b); end end
module tb_top;
    timeunit 1ns;
    timeprecision 100ps;
    typedef struct {logic [31:0] e; logic [31:0] m; logic r;} bdt_note_t;
    bdt_note_t q[$];
    bdt_note_t n;
    logic clk, nrst, psel, penable, pwrite, go, strap, pready, pslverr, ext, aro, tout, pol;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, h, c;
    logic [7:0] npul;
    int num_errors = 0;
    int checked = 0;
    int seed = 32'h683c_f439;
    int nsel[4] = '{13, 10, 8, 16};
    bdt_timer u_dut (.i_core_clk(clk), .i_nrst(nrst), .i_psel(psel), .i_penable(penable), .i_pwrite(pwrite),
        .i_paddr(paddr), .i_pwdata(pwdata), .o_pready(pready), .o_prdata(prdata), .o_pslverr(pslverr),
        .i_auto_reset_off(aro), .i_osc_ext_clk(ext), .o_timer_out(tout));
    bdt_ext_ctrl u_far (.i_core_clk(clk), .i_strap(strap), .i_go(go), .i_pulses(npul),
        .o_auto_reset_off(aro), .o_ext_clk(ext));
    // 40 mhz clock
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    // verdict and end of run
    task automatic wrap_up();
        $display("compares %0d mismatches %0d", checked, num_errors);
        if (num_errors == 0 && checked > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    // watchdog: tests need about 76k cycles
    initial begin
        #(25 * 95000);
        num_errors++;
        wrap_up();
    end
    // one apb transfer; the expected answer is queued first
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d, e, m, input logic r);
        q.push_back('{e, m, r});
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        // only the watchdog ends a wait for ready
        do begin
            @(posedge clk);
        end while (pready !== 1'b1);
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        apb(1'b1, a, d, 32'h0, 32'h0, 1'b0);
    endtask
    task automatic rd(input logic [11:0] a, input logic [31:0] e, m, input logic r);
        apb(1'b0, a, 32'h0, e, m, r);
    endtask
    // monitor: oldest note against each answer; pin checked whenever the mask covers bit 16
    always @(posedge clk) begin
        if (pready === 1'b1 && q.size() > 0) begin
            n = q.pop_front();
            `CHK(prdata & n.m, n.e)
            `CHK(pslverr, n.r)
            if (n.m[16]) `CHK(tout, n.e[16])
        end
    end
    // main sequence
    initial begin
        strap = 1'($random(seed));
        {nrst, psel, penable, pwrite, go} = 5'h0;
        paddr = 12'h000;
        pwdata = 32'h0;
        npul = 8'h00;
        repeat (2) @(posedge clk);
        nrst <= 1'b1;
        repeat (10) @(posedge clk);
        rd(`BDT_ADDR_STAT, {12'h000, strap, 19'h0_0000}, 32'h0008_0000, 1'b0);
        rd(`BDT_ADDR_CTRL, 32'h0000_0008, 32'hFFFF_FFFF, 1'b0);
        rd(`BDT_ADDR_DIV, 32'h0000_0003, 32'hFFFF_FFFF, 1'b0);
        rd(12'h010, 32'h0, 32'hFFFF_FFFF, 1'b1);
        wr(`BDT_ADDR_DIV, 32'h0);
        rd(`BDT_ADDR_DIV, 32'h0, 32'hFFFF_FFFF, 1'b0);
        $display("test registers done");
        for (int s = 0; s < 4; s++) begin
            pol = 1'($random(seed));
            h = 32'h1 << (nsel[s] - 1);
            c = {29'h0, pol, 2'(s)};
            wr(`BDT_ADDR_CTRL, c | 32'h0000_0010);
            repeat (20) @(posedge clk);
            rd(`BDT_ADDR_STAT, {13'h0, 1'b1, 1'b0, pol, 16'h0}, 32'h0007_FFFF, 1'b0);
            wr(`BDT_ADDR_CTRL, c);
            repeat (h - 40) @(posedge clk);
            rd(`BDT_ADDR_STAT, {15'h0, pol, 16'h0}, 32'h0001_0000, 1'b0);
            repeat (80) @(posedge clk);
            rd(`BDT_ADDR_STAT, {14'h0, 1'b1, ~pol, 16'h0}, 32'h0003_0000, 1'b0);
            repeat (h) @(posedge clk);
            rd(`BDT_ADDR_STAT, {14'h0, 1'b1, ~pol, 16'h0}, 32'h0003_0000, 1'b0);
            $display("test single select %0d done", s);
        end
        // recycle, inverted level, divide by 256
        wr(`BDT_ADDR_CTRL, 32'h0000_001E);
        wr(`BDT_ADDR_CTRL, 32'h0000_000E);
        repeat (180) @(posedge clk);
        rd(`BDT_ADDR_STAT, 32'h0, 32'h0001_00FF, 1'b0);
        repeat (100) @(posedge clk);
        rd(`BDT_ADDR_STAT, 32'h0001_0000, 32'h0001_00FF, 1'b0);
        $display("test recycle done");
        // external clock bursts, first while held in reset
        npul <= 8'(($random(seed) & 32'h1F) + 8);
        wr(`BDT_ADDR_CTRL, 32'h0000_003B);
        go <= 1'b1;
        repeat (8 * npul + 10) @(posedge clk);
        rd(`BDT_ADDR_STAT, 32'h0, 32'h0000_FFFF, 1'b0);
        go <= 1'b0;
        wr(`BDT_ADDR_CTRL, 32'h0000_002B);
        go <= 1'b1;
        repeat (8 * npul + 10) @(posedge clk);
        rd(`BDT_ADDR_STAT, {24'h00_0000, npul}, 32'h0000_FFFF, 1'b0);
        go <= 1'b0;
        $display("test bypass done");
        repeat (5) @(posedge clk);
        wrap_up();
    end
endmodule
